// [rtl/udi_regs.v]
// Overview of operation
// - Short character lengths send only the low bits of the written byte.
// - FIFO mode queues up to sixteen transmit bytes.
// - Non-FIFO mode holds exactly one transmit byte.
// - Transmit write, receive read and divisor low byte share offset zero.
// - Interrupt enable shares offset four with the divisor high byte.
// - Divisor-access bit steers offsets zero and four to divisor bytes.
// - Enable bit 4 raises transmit-complete when holding and shifter are empty.
// - Enable bit 3 raises an interrupt on any modem status edge.
// - Enable bit 2 raises line status on parity, framing, overrun or break.
// - Enable bit 1 raises an interrupt while transmit buffer is empty.
// - Enable bit 0 raises an interrupt on receive data ready or timeout.
// - FIFO mode receive ready asserts at fill level 1, 4, 8 or 14.
// - Identification bits 7:6 report fifo state 00, 10 or 11.
// - Identification code bits 3:1 valid only while pending bit is zero.
// - Only the highest priority pending source is shown.
// - Codes by priority: 011, 010, 110, 101, 001, 000.
// - Bit 0 reads zero while any source is active, resets to one.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "udi_defines.vh"

module udi_regs #(
  parameter ADDR_W = 12,
  parameter FIFO_DEPTH = 16,
  parameter PTR_W = 4,
  parameter CNT_W = 5
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire [ADDR_W-1:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [ADDR_W-1:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg o_tx_valid,
  output reg [7:0] o_tx_data,
  input wire i_tx_ready,
  input wire i_tx_shift_empty,
  input wire i_rx_valid,
  input wire [7:0] i_rx_data,
  input wire i_rx_timeout,
  input wire [3:0] i_line_err,
  input wire i_modem_edge,
  output reg [15:0] o_divisor,
  output reg [1:0] o_char_len,
  output reg o_irq
);

  // Register select codes
  localparam [2:0] SEL_DATA = 3'h0;
  localparam [2:0] SEL_IEN = 3'h1;
  localparam [2:0] SEL_IID = 3'h2;
  localparam [2:0] SEL_LCTL = 3'h3;
  localparam [2:0] SEL_MODE = 3'h4;
  localparam [2:0] SEL_EVT = 3'h5;
  localparam [2:0] SEL_EVTMSK = 3'h6;
  localparam [2:0] SEL_NONE = 3'h7;

  // Address decode shared by read and write paths
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `UDI_OFS_DATA: reg_sel = SEL_DATA;
        `UDI_OFS_IEN: reg_sel = SEL_IEN;
        `UDI_OFS_IID: reg_sel = SEL_IID;
        `UDI_OFS_LCTL: reg_sel = SEL_LCTL;
        `UDI_OFS_MODE: reg_sel = SEL_MODE;
        `UDI_OFS_EVT: reg_sel = SEL_EVT;
        `UDI_OFS_EVTMSK: reg_sel = SEL_EVTMSK;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  reg aw_held_ff;
  reg w_held_ff;
  reg [ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg wstrb0_ff;
  reg [`UDI_IEN_W-1:0] ien_ff;
  reg [7:0] lctl_ff;
  reg fifo_en_ff;
  reg [1:0] trig_ff;
  reg mdrop_ff;
  reg [`UDI_EVT_W-1:0] evt_ff;
  reg [`UDI_EVT_W-1:0] evtmsk_ff;
  reg txc_lvl_ff;
  reg [7:0] tx_mem [0:FIFO_DEPTH-1];
  reg [PTR_W-1:0] tx_wr_ff;
  reg [PTR_W-1:0] tx_rd_ff;
  reg [CNT_W-1:0] tx_cnt_ff;
  reg [7:0] rx_mem [0:FIFO_DEPTH-1];
  reg [PTR_W-1:0] rx_wr_ff;
  reg [PTR_W-1:0] rx_rd_ff;
  reg [CNT_W-1:0] rx_cnt_ff;

  wire wr_go;
  wire [2:0] wsel;
  wire [2:0] rsel;
  wire rd_go;
  wire dlab;
  wire wr_lane;
  wire [CNT_W-1:0] tx_cap;
  wire [CNT_W-1:0] rx_cap;
  wire tx_push;
  wire tx_pop;
  wire tx_clr;
  wire rx_push;
  wire rx_pop;
  wire rx_clr;
  wire txc_lvl;
  wire [`UDI_EVT_W-1:0] evt_in;
  wire [`UDI_EVT_W-1:0] evt_w1c;
  wire [PTR_W-1:0] tx_rd_nx;
  reg [CNT_W-1:0] nxt_tx_cnt;
  reg [7:0] nxt_tx_data;
  reg [7:0] tx_byte;
  reg [CNT_W-1:0] rx_trig;
  reg rx_rdy;
  reg [1:0] fifo_sts;
  reg [2:0] nxt_iid;
  reg nxt_pend;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;

  // Bus handshake terms
  assign wr_go = aw_held_ff && w_held_ff && !o_s_axi_bvalid;
  assign wsel = reg_sel(awaddr_ff);
  assign rsel = reg_sel(i_s_axi_araddr);
  assign rd_go = i_s_axi_arvalid && o_s_axi_arready;
  assign dlab = lctl_ff[`UDI_LCTL_DLAB];
  assign wr_lane = wr_go && wstrb0_ff;

  // Buffer capacity follows fifo mode
  assign tx_cap = fifo_en_ff ? FIFO_DEPTH[CNT_W-1:0] : {{(CNT_W-1){1'b0}}, 1'b1};
  assign rx_cap = (fifo_en_ff && !mdrop_ff) ? FIFO_DEPTH[CNT_W-1:0]
                                            : {{(CNT_W-1){1'b0}}, 1'b1};

  // Fifo movement
  assign tx_push = wr_lane && (wsel == SEL_DATA) && !dlab && (tx_cnt_ff < tx_cap);
  assign tx_pop = o_tx_valid && i_tx_ready;
  assign tx_clr = wr_lane && (wsel == SEL_IID) && wdata_ff[`UDI_FCR_CLRTX];
  assign rx_push = i_rx_valid && (rx_cnt_ff < rx_cap);
  assign rx_pop = rd_go && (rsel == SEL_DATA) && !dlab && (rx_cnt_ff != {CNT_W{1'b0}});
  assign rx_clr = wr_lane && (wsel == SEL_IID) && wdata_ff[`UDI_FCR_CLRRX];
  assign tx_rd_nx = tx_rd_ff + {{(PTR_W-1){1'b0}}, 1'b1};

  // Transmit complete level and event sources
  assign txc_lvl = (tx_cnt_ff == {CNT_W{1'b0}}) && i_tx_shift_empty;
  assign evt_in[`UDI_EVT_LINE] = |i_line_err;
  assign evt_in[`UDI_EVT_TOUT] = i_rx_timeout;
  assign evt_in[`UDI_EVT_TXC] = txc_lvl && !txc_lvl_ff;
  assign evt_in[`UDI_EVT_MODEM] = i_modem_edge;
  assign evt_w1c = (wr_lane && (wsel == SEL_EVT)) ? wdata_ff[`UDI_EVT_W-1:0]
                                                  : {`UDI_EVT_W{1'b0}};

  // Masking of the written byte to the character length
  always @* begin
    case (lctl_ff[`UDI_LCTL_LEN_HI:`UDI_LCTL_LEN_LO])
      2'h0: tx_byte = {3'h0, wdata_ff[4:0]};
      2'h1: tx_byte = {2'h0, wdata_ff[5:0]};
      2'h2: tx_byte = {1'h0, wdata_ff[6:0]};
      default: tx_byte = wdata_ff[7:0];
    endcase
  end

  // Next transmit count and head byte
  always @* begin
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_data = o_tx_data;
    if (tx_clr) begin
      nxt_tx_cnt = {CNT_W{1'b0}};
    end else begin
      nxt_tx_cnt = tx_cnt_ff + {{(CNT_W-1){1'b0}}, tx_push} - {{(CNT_W-1){1'b0}}, tx_pop};
      if (tx_pop) begin
        nxt_tx_data = (tx_cnt_ff > {{(CNT_W-1){1'b0}}, 1'b1}) ? tx_mem[tx_rd_nx] : tx_byte;
      end else if (tx_cnt_ff == {CNT_W{1'b0}}) begin
        nxt_tx_data = tx_byte;
      end
    end
  end

  // Receive trigger level and fifo state
  always @* begin
    case (trig_ff)
      2'h0: rx_trig = `UDI_TRIG_1;
      2'h1: rx_trig = `UDI_TRIG_4;
      2'h2: rx_trig = `UDI_TRIG_8;
      default: rx_trig = `UDI_TRIG_14;
    endcase
    if (fifo_en_ff && !mdrop_ff) begin
      rx_rdy = (rx_cnt_ff >= rx_trig);
    end else begin
      rx_rdy = (rx_cnt_ff != {CNT_W{1'b0}});
    end
    if (!fifo_en_ff) begin
      fifo_sts = `UDI_STS_OFF;
    end else if (mdrop_ff) begin
      fifo_sts = `UDI_STS_MDROP;
    end else begin
      fifo_sts = `UDI_STS_ON;
    end
  end

  // Fixed priority identification
  always @* begin
    nxt_pend = 1'b1;
    nxt_iid = `UDI_IID_MODEM;
    if (ien_ff[`UDI_IEN_LINE] && evt_ff[`UDI_EVT_LINE] && evtmsk_ff[`UDI_EVT_LINE]) begin
      nxt_pend = 1'b0;
      nxt_iid = `UDI_IID_LINE;
    end else if (ien_ff[`UDI_IEN_RX] && rx_rdy) begin
      nxt_pend = 1'b0;
      nxt_iid = `UDI_IID_RXD;
    end else if (ien_ff[`UDI_IEN_RX] && evt_ff[`UDI_EVT_TOUT] && evtmsk_ff[`UDI_EVT_TOUT]) begin
      nxt_pend = 1'b0;
      nxt_iid = `UDI_IID_TOUT;
    end else if (ien_ff[`UDI_IEN_TXC] && evt_ff[`UDI_EVT_TXC] && evtmsk_ff[`UDI_EVT_TXC]) begin
      nxt_pend = 1'b0;
      nxt_iid = `UDI_IID_TXC;
    end else if (ien_ff[`UDI_IEN_TXE] && (tx_cnt_ff == {CNT_W{1'b0}})) begin
      nxt_pend = 1'b0;
      nxt_iid = `UDI_IID_TXE;
    end else if (ien_ff[`UDI_IEN_MODEM] && evt_ff[`UDI_EVT_MODEM]
                 && evtmsk_ff[`UDI_EVT_MODEM]) begin
      nxt_pend = 1'b0;
      nxt_iid = `UDI_IID_MODEM;
    end
  end

  // Read data mux
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `UDI_RESP_OKAY;
    case (rsel)
      SEL_DATA: begin
        if (dlab) begin
          nxt_rdata = {24'h00_0000, o_divisor[7:0]};
        end else if (rx_cnt_ff != {CNT_W{1'b0}}) begin
          nxt_rdata = {24'h00_0000, rx_mem[rx_rd_ff]};
        end
      end
      SEL_IEN: begin
        if (dlab) begin
          nxt_rdata = {24'h00_0000, o_divisor[15:8]};
        end else begin
          nxt_rdata = {27'h000_0000, ien_ff};
        end
      end
      SEL_IID: begin
        nxt_rdata = {24'h00_0000, fifo_sts, 2'h0, nxt_iid, nxt_pend};
      end
      SEL_LCTL: begin
        nxt_rdata = {24'h00_0000, lctl_ff};
      end
      SEL_MODE: begin
        nxt_rdata = {31'h0000_0000, mdrop_ff};
      end
      SEL_EVT: begin
        nxt_rdata = {28'h000_0000, evt_ff};
      end
      SEL_EVTMSK: begin
        nxt_rdata = {28'h000_0000, evtmsk_ff};
      end
      default: begin
        nxt_rresp = `UDI_RESP_DECERR;
      end
    endcase
  end

  // Write channel capture and response
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= {ADDR_W{1'b0}};
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `UDI_RESP_OKAY;
    end else if (i_ce) begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= i_s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= i_s_axi_wdata;
        wstrb0_ff <= i_s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
      o_s_axi_awready <= !aw_held_ff && !(i_s_axi_awvalid && o_s_axi_awready)
                         && !o_s_axi_bvalid;
      o_s_axi_wready <= !w_held_ff && !(i_s_axi_wvalid && o_s_axi_wready)
                        && !o_s_axi_bvalid;
      if (wr_go) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (wsel == SEL_NONE) ? `UDI_RESP_DECERR : `UDI_RESP_OKAY;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `UDI_RESP_OKAY;
    end else if (i_ce) begin
      o_s_axi_arready <= !o_s_axi_rvalid && !rd_go;
      if (rd_go) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= nxt_rdata;
        o_s_axi_rresp <= nxt_rresp;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ien_ff <= {`UDI_IEN_W{1'b0}};
      lctl_ff <= 8'h00;
      o_divisor <= 16'h0000;
      o_char_len <= 2'h0;
      fifo_en_ff <= 1'b0;
      trig_ff <= 2'h0;
      mdrop_ff <= 1'b0;
      evtmsk_ff <= `UDI_EVTMSK_RST;
    end else if (i_ce && wr_lane) begin
      case (wsel)
        SEL_DATA: begin
          if (dlab) begin
            o_divisor[7:0] <= wdata_ff[7:0];
          end
        end
        SEL_IEN: begin
          if (dlab) begin
            o_divisor[15:8] <= wdata_ff[7:0];
          end else begin
            ien_ff <= wdata_ff[`UDI_IEN_W-1:0];
          end
        end
        SEL_IID: begin
          fifo_en_ff <= wdata_ff[`UDI_FCR_EN];
          trig_ff <= wdata_ff[`UDI_FCR_TRIG_HI:`UDI_FCR_TRIG_LO];
        end
        SEL_LCTL: begin
          lctl_ff <= wdata_ff[7:0];
          o_char_len <= wdata_ff[`UDI_LCTL_LEN_HI:`UDI_LCTL_LEN_LO];
        end
        SEL_MODE: begin
          mdrop_ff <= wdata_ff[`UDI_MODE_MDROP];
        end
        SEL_EVTMSK: begin
          evtmsk_ff <= wdata_ff[`UDI_EVT_W-1:0];
        end
        default: begin
          mdrop_ff <= mdrop_ff;
        end
      endcase
    end
  end

  // Sticky events, set wins over write-one-clear, and interrupt output
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_ff <= {`UDI_EVT_W{1'b0}};
      txc_lvl_ff <= 1'b1;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      evt_ff <= (evt_ff & ~evt_w1c) | evt_in;
      txc_lvl_ff <= txc_lvl;
      o_irq <= !nxt_pend;
    end
  end

  // Transmit fifo
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_wr_ff <= {PTR_W{1'b0}};
      tx_rd_ff <= {PTR_W{1'b0}};
      tx_cnt_ff <= {CNT_W{1'b0}};
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
    end else if (i_ce) begin
      if (tx_clr) begin
        tx_wr_ff <= {PTR_W{1'b0}};
        tx_rd_ff <= {PTR_W{1'b0}};
      end else begin
        if (tx_push) begin
          tx_wr_ff <= tx_wr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        end
        if (tx_pop) begin
          tx_rd_ff <= tx_rd_nx;
        end
      end
      tx_cnt_ff <= nxt_tx_cnt;
      o_tx_valid <= (nxt_tx_cnt != {CNT_W{1'b0}});
      o_tx_data <= nxt_tx_data;
    end
  end

  // Fifo storage, no reset needed
  always @(posedge i_clk) begin
    if (i_ce && tx_push) begin
      tx_mem[tx_wr_ff] <= tx_byte;
    end
    if (i_ce && rx_push) begin
      rx_mem[rx_wr_ff] <= i_rx_data;
    end
  end

  // Receive fifo pointers and count
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_wr_ff <= {PTR_W{1'b0}};
      rx_rd_ff <= {PTR_W{1'b0}};
      rx_cnt_ff <= {CNT_W{1'b0}};
    end else if (i_ce) begin
      if (rx_clr) begin
        rx_wr_ff <= {PTR_W{1'b0}};
        rx_rd_ff <= {PTR_W{1'b0}};
        rx_cnt_ff <= {CNT_W{1'b0}};
      end else begin
        if (rx_push) begin
          rx_wr_ff <= rx_wr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        end
        if (rx_pop) begin
          rx_rd_ff <= rx_rd_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        end
        rx_cnt_ff <= rx_cnt_ff + {{(CNT_W-1){1'b0}}, rx_push}
                     - {{(CNT_W-1){1'b0}}, rx_pop};
      end
    end
  end

endmodule // udi_regs

// [shared/udi_defines.vh]
`ifndef UDI_DEFINES_VH
`define UDI_DEFINES_VH

// Register word offsets (byte addresses)
`define UDI_OFS_DATA 12'h000
`define UDI_OFS_IEN 12'h004
`define UDI_OFS_IID 12'h008
`define UDI_OFS_LCTL 12'h00C
`define UDI_OFS_MODE 12'h024
`define UDI_OFS_EVT 12'h028
`define UDI_OFS_EVTMSK 12'h02C

// Interrupt enable bits
`define UDI_IEN_RX 0
`define UDI_IEN_TXE 1
`define UDI_IEN_LINE 2
`define UDI_IEN_MODEM 3
`define UDI_IEN_TXC 4
`define UDI_IEN_W 5

// FIFO control fields (write side of the identification offset)
`define UDI_FCR_EN 0
`define UDI_FCR_CLRRX 1
`define UDI_FCR_CLRTX 2
`define UDI_FCR_TRIG_HI 7
`define UDI_FCR_TRIG_LO 6

// Line control fields
`define UDI_LCTL_DLAB 7
`define UDI_LCTL_LEN_HI 1
`define UDI_LCTL_LEN_LO 0

// Mode register fields
`define UDI_MODE_MDROP 0

// Event status bits
`define UDI_EVT_LINE 0
`define UDI_EVT_TOUT 1
`define UDI_EVT_TXC 2
`define UDI_EVT_MODEM 3
`define UDI_EVT_W 4
`define UDI_EVTMSK_RST 4'hF

// Identification codes and fifo state
`define UDI_IID_LINE 3'h3
`define UDI_IID_RXD 3'h2
`define UDI_IID_TOUT 3'h6
`define UDI_IID_TXC 3'h5
`define UDI_IID_TXE 3'h1
`define UDI_IID_MODEM 3'h0
`define UDI_STS_OFF 2'h0
`define UDI_STS_MDROP 2'h2
`define UDI_STS_ON 2'h3

// Receive trigger fill levels
`define UDI_TRIG_1 5'h01
`define UDI_TRIG_4 5'h04
`define UDI_TRIG_8 5'h08
`define UDI_TRIG_14 5'h0E

// Bus responses
`define UDI_RESP_OKAY 2'h0
`define UDI_RESP_DECERR 2'h3

`endif

// [sim/udi_regs_asserts.sv]
`timescale 1ns/10ps
`include "udi_defines.vh"

module udi_regs_chk #(
  parameter ADDR_W = 12
) (
  input wire i_clk,
  input wire i_rst,
  input wire [ADDR_W-1:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire [1:0] o_s_axi_rresp,
  input wire o_s_axi_rvalid,
  input wire o_tx_valid,
  input wire [7:0] o_tx_data,
  input wire i_tx_ready,
  input wire [1:0] o_char_len,
  input wire o_irq
);
  reg rd_iid_ff;
  // Address decode seen by the checker
  wire ar_hs = i_s_axi_arvalid && o_s_axi_arready;
  wire [ADDR_W-1:0] ra = i_s_axi_araddr;
  wire hit = (ra == `UDI_OFS_DATA) || (ra == `UDI_OFS_IEN) || (ra == `UDI_OFS_IID) ||
    (ra == `UDI_OFS_LCTL) || (ra == `UDI_OFS_MODE) || (ra == `UDI_OFS_EVT) ||
    (ra == `UDI_OFS_EVTMSK);
  wire [1:0] rsp_exp = hit ? `UDI_RESP_OKAY : `UDI_RESP_DECERR;
  wire iid_rd = o_s_axi_rvalid && rd_iid_ff;

  // Remember whether the read in flight targets the identification word
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_iid_ff <= 1'b0;
    end else if (ar_hs) begin
      rd_iid_ff <= (ra == `UDI_OFS_IID);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_len_mask: assert property (
    o_tx_valid |-> (o_tx_data >> (5 + o_char_len)) == 8'h00)
    else $error("tx byte wider than char length");
  a_tx_hold: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx byte changed before taken");
  a_tx_take: assert property (
    $fell(o_tx_valid) |-> $past(i_tx_ready))
    else $error("tx byte vanished untaken");
  a_iid_fields: assert property (
    iid_rd |-> o_s_axi_rdata[5:4] == 2'h0 && o_s_axi_rdata[7:6] != 2'h1)
    else $error("bad identification fields");
  a_iid_code: assert property (
    iid_rd && !o_s_axi_rdata[0] |-> o_s_axi_rdata[3:1] != 3'h4 && o_s_axi_rdata[3:1] != 3'h7)
    else $error("illegal identification code");
  a_irq_rst: assert property (
    $fell(i_rst) |-> !o_irq [*2])
    else $error("irq high after reset");
  a_rd_answer: assert property (
    ar_hs |=> o_s_axi_rvalid && o_s_axi_rresp == $past(rsp_exp))
    else $error("read answer late or wrong response");
  a_rd_upper: assert property (
    o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
    else $error("reserved read bits set");

  c_tx_take: cover property (o_tx_valid && i_tx_ready);
  c_pending: cover property (iid_rd && !o_s_axi_rdata[0]);
  c_unmapped: cover property (ar_hs && !hit);
endmodule // udi_regs_chk

// [sim/udi_regs_tb.sv]
`timescale 1ns/10ps
`include "udi_defines.vh"
`define CHK(n, x, y) begin n_compared = n_compared + 1; if ((y) !== (x)) begin \
  fails = fails + 1; $display("Error %s expected %0h seen %0h", n, x, y); end end

module udi_regs_tb;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [11:0] aw_a = 12'h000;
  reg [11:0] ar_a = 12'h000;
  reg [31:0] w_d = 32'h0;
  reg aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, stall = 1'b0;
  wire aw_r, w_r, b_v, ar_r, r_v, tv, tr, se, xv, xt, me, irq;
  wire [1:0] b_p, r_p, cl;
  wire [31:0] r_d;
  wire [7:0] td, xd;
  wire [3:0] le;
  wire [15:0] dv;
  integer fails = 0, n_compared = 0, cyc = 0, i, j, k;
  reg [31:0] v;
  reg [1:0] r;
  reg aw, w;

  udi_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_s_axi_awaddr(aw_a),
    .i_s_axi_awvalid(aw_v), .o_s_axi_awready(aw_r), .i_s_axi_wdata(w_d),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(w_v), .o_s_axi_wready(w_r), .o_s_axi_bresp(b_p),
    .o_s_axi_bvalid(b_v), .i_s_axi_bready(b_r), .i_s_axi_araddr(ar_a),
    .i_s_axi_arvalid(ar_v), .o_s_axi_arready(ar_r), .o_s_axi_rdata(r_d),
    .o_s_axi_rresp(r_p), .o_s_axi_rvalid(r_v), .i_s_axi_rready(r_r), .o_tx_valid(tv),
    .o_tx_data(td), .i_tx_ready(tr), .i_tx_shift_empty(se), .i_rx_valid(xv),
    .i_rx_data(xd), .i_rx_timeout(xt), .i_line_err(le), .i_modem_edge(me),
    .o_divisor(dv), .o_char_len(cl), .o_irq(irq));
  udi_xcvr_model xcvr (.i_clk(i_clk), .i_rst(i_rst), .i_stall(stall), .i_tx_valid(tv),
    .i_tx_data(td), .o_tx_ready(tr), .o_shift_empty(se), .o_rx_valid(xv), .o_rx_data(xd),
    .o_rx_timeout(xt), .o_line_err(le), .o_modem_edge(me));

  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;

  // Write: address and data together, each released when taken
  task wr(input [11:0] a, input [31:0] d);
    begin
      aw = 1'b1;
      w = 1'b1;
      @(posedge i_clk);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      while (aw || w) begin
        @(posedge i_clk);
        if (aw_r) aw_v <= 1'b0;
        if (w_r) w_v <= 1'b0;
        aw = aw && !aw_r;
        w = w && !w_r;
      end
      while (!b_v) @(posedge i_clk);
      r = b_p;
      b_r <= 1'b0;
    end
  endtask

  // Read: result in v, response in r
  task rd(input [11:0] a);
    begin
      @(posedge i_clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      @(posedge i_clk);
      while (!ar_r) @(posedge i_clk);
      ar_v <= 1'b0;
      while (!r_v) @(posedge i_clk);
      v = r_d;
      r = r_p;
      r_r <= 1'b0;
    end
  endtask

  // Identification word and irq line together
  task chk_iid(input [7:0] x);
    begin
      rd(`UDI_OFS_IID);
      `CHK("identification", {24'h0, x}, v)
      `CHK("irq", ~x[0], irq)
    end
  endtask

  // Wait until the transmitter has sent everything
  task drain;
    begin
      repeat (2) @(posedge i_clk);
      while (tv || !se) @(posedge i_clk);
      repeat (3) @(posedge i_clk);
    end
  endtask

  task end_sim;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_sim;
    end
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values and unmapped space
    chk_iid(8'h01);
    rd(`UDI_OFS_IEN);
    `CHK("enable reset", 32'h0, v)
    rd(12'h040);
    `CHK("unmapped read", `UDI_RESP_DECERR, r)
    wr(12'h040, 32'h1);
    `CHK("unmapped write", `UDI_RESP_DECERR, r)
    $display("Test reset done");
    // Divisor bytes behind the shared offsets
    wr(`UDI_OFS_LCTL, 32'h83);
    wr(`UDI_OFS_DATA, 32'h34);
    wr(`UDI_OFS_IEN, 32'h12);
    `CHK("divisor", 16'h1234, dv)
    rd(`UDI_OFS_DATA);
    `CHK("divisor low", 32'h34, v)
    wr(`UDI_OFS_LCTL, 32'h03);
    rd(`UDI_OFS_IEN);
    `CHK("enable apart", 32'h0, v)
    `CHK("no tx push", 1'b0, tv)
    $display("Test divisor done");
    // Character length trims the sent byte
    for (i = 0; i < 4; i = i + 1) begin
      wr(`UDI_OFS_LCTL, i);
      `CHK("char length", i[1:0], cl)
      wr(`UDI_OFS_DATA, 32'hFF);
      drain;
      `CHK("sent bits", 8'hFF >> (3 - i), xcvr.last_ff)
    end
    $display("Test length done");
    // Single buffer, then sixteen-deep queue, with the far side stalled
    stall <= 1'b1;
    k = xcvr.n_got;
    for (i = 0; i < 3; i = i + 1) wr(`UDI_OFS_DATA, 32'hA0 + i);
    stall <= 1'b0;
    drain;
    `CHK("single depth", k + 1, xcvr.n_got)
    `CHK("single byte", 8'hA0, xcvr.last_ff)
    wr(`UDI_OFS_IID, 32'h01);
    stall <= 1'b1;
    for (i = 0; i < 17; i = i + 1) wr(`UDI_OFS_DATA, i);
    stall <= 1'b0;
    drain;
    `CHK("fifo depth", k + 17, xcvr.n_got)
    `CHK("fifo last", 8'h0F, xcvr.last_ff)
    $display("Test depth done");
    // Receive trigger levels and read order
    wr(`UDI_OFS_IEN, 32'h01);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`UDI_OFS_IID, 32'h03 | (i << 6));
      k = (i == 0) ? 1 : (i == 1) ? 4 : (i == 2) ? 8 : 14;
      for (j = 0; j < k - 1; j = j + 1) xcvr.evt(2'd0, 8'h40 + j);
      chk_iid(8'hC1);
      xcvr.evt(2'd0, 8'h40 + k - 1);
      chk_iid(8'hC4);
      for (j = 0; j < k; j = j + 1) begin
        rd(`UDI_OFS_DATA);
        `CHK("rx order", 32'h40 + j, v)
      end
    end
    wr(`UDI_OFS_MODE, 32'h01);
    chk_iid(8'h81);
    wr(`UDI_OFS_MODE, 32'h00);
    wr(`UDI_OFS_IID, 32'h00);
    chk_iid(8'h01);
    $display("Test receive done");
    // Priority walk through every source
    wr(`UDI_OFS_EVT, 32'h0F);
    wr(`UDI_OFS_IEN, 32'h02);
    chk_iid(8'h02);
    wr(`UDI_OFS_IEN, 32'h1F);
    xcvr.evt(2'd3, 8'h00);
    chk_iid(8'h02);
    for (i = 0; i < 4; i = i + 1) begin
      xcvr.evt(2'd2, 8'h01 << i);
      chk_iid(8'h06);
      wr(`UDI_OFS_EVT, 32'h01);
    end
    xcvr.evt(2'd0, 8'h5A);
    chk_iid(8'h04);
    xcvr.evt(2'd1, 8'h00);
    chk_iid(8'h04);
    rd(`UDI_OFS_DATA);
    `CHK("rx byte", 32'h5A, v)
    chk_iid(8'h0C);
    rd(`UDI_OFS_DATA);
    `CHK("rx empty", 32'h0, v)
    wr(`UDI_OFS_EVT, 32'h02);
    chk_iid(8'h02);
    wr(`UDI_OFS_IEN, 32'h08);
    chk_iid(8'h00);
    wr(`UDI_OFS_EVTMSK, 32'h07);
    chk_iid(8'h01);
    wr(`UDI_OFS_EVTMSK, 32'h0F);
    chk_iid(8'h00);
    wr(`UDI_OFS_EVT, 32'h08);
    chk_iid(8'h01);
    wr(`UDI_OFS_IEN, 32'h10);
    wr(`UDI_OFS_DATA, 32'h33);
    drain;
    chk_iid(8'h0A);
    wr(`UDI_OFS_EVT, 32'h04);
    chk_iid(8'h01);
    $display("Test priority done");
    end_sim;
  end
endmodule // udi_regs_tb

bind udi_regs udi_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .o_char_len(o_char_len), .o_irq(o_irq));

// [sim/udi_xcvr_model.sv]
`timescale 1ns/10ps

module udi_xcvr_model (
  input wire i_clk,
  input wire i_rst,
  input wire i_stall,
  input wire i_tx_valid,
  input wire [7:0] i_tx_data,
  output wire o_tx_ready,
  output wire o_shift_empty,
  output reg o_rx_valid,
  output reg [7:0] o_rx_data,
  output reg o_rx_timeout,
  output reg [3:0] o_line_err,
  output reg o_modem_edge
);
  integer n_got = 0;
  reg [7:0] last_ff = 8'h00;
  reg [2:0] shift_ff = 3'h0;

  // Idle receive side at start
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_timeout = 1'b0;
    o_line_err = 4'h0;
    o_modem_edge = 1'b0;
  end

  // Shifter busy a few cycles per byte; stall holds ready low
  assign o_shift_empty = (shift_ff == 3'h0);
  assign o_tx_ready = o_shift_empty && !i_stall;

  // Take bytes and count them
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      n_got <= 0;
      shift_ff <= 3'h0;
    end else if (i_tx_valid && o_tx_ready) begin
      n_got <= n_got + 1;
      last_ff <= i_tx_data;
      shift_ff <= 3'h6;
    end else if (!o_shift_empty) begin
      shift_ff <= shift_ff - 3'h1;
    end
  end

  // One-cycle event: 0 rx byte, 1 timeout, 2 line error, 3 modem edge
  task evt(input [1:0] kind, input [7:0] b);
    begin
      @(posedge i_clk);
      o_rx_data <= b;
      o_rx_valid <= (kind == 2'd0);
      o_rx_timeout <= (kind == 2'd1);
      o_line_err <= (kind == 2'd2) ? b[3:0] : 4'h0;
      o_modem_edge <= (kind == 2'd3);
      @(posedge i_clk);
      o_rx_data <= ~b;
      o_rx_valid <= 1'b0;
      o_rx_timeout <= 1'b0;
      o_line_err <= 4'h0;
      o_modem_edge <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule // udi_xcvr_model
